// >>> softmix_pkg.sv
// Package: constants, register map and carriers for the component soft mixer
package softmix_pkg;
    // ========================================
    // Register byte addresses
    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_MIX = 8'h04;
    localparam logic [7:0] REG_PICT = 8'h08;
    localparam logic [7:0] REG_SAT = 8'h0c;
    localparam logic [7:0] REG_STAT = 8'h10;
    // ========================================
    // Mode register field positions
    localparam int MODE_SRC_LSB = 0;
    localparam int MODE_CLAMP_BIT = 2;
    localparam int MODE_CURVE_BIT = 3;
    localparam int MODE_DELAY_BIT = 4;
    localparam int MODE_YUV_BIT = 5;
    localparam int MODE_LPFBY_BIT = 6;
    localparam int MODE_XAR_BIT = 7;
    // Mix register: gain [5:0], offset [13:8]
    localparam int MIX_GAIN_LSB = 0;
    localparam int MIX_OFFS_LSB = 8;
    // Picture register: contrast [5:0], brightness [15:8], tint [23:16]
    localparam int PICT_CON_LSB = 0;
    localparam int PICT_BRI_LSB = 8;
    localparam int PICT_TINT_LSB = 16;
    // Saturation register: cr [5:0], cb [13:8]
    localparam int SAT_CR_LSB = 0;
    localparam int SAT_CB_LSB = 8;
    // Status bits
    localparam int ST_HIGH_BIT = 0;
    localparam int ST_NOW_BIT = 1;
    localparam int ST_RISE_BIT = 2;
    localparam int ST_FALL_BIT = 3;
    localparam int ST_CLIP_BIT = 4;
    // ========================================
    // Reset values
    localparam logic [1:0] SRC_MAIN = 2'b11;
    localparam logic [1:0] SRC_MIX = 2'b01;
    localparam logic [7:0] MODE_RESET = 8'h03;
    localparam logic [13:0] MIX_RESET = 14'h0000;
    localparam logic [23:0] PICT_RESET = 24'h00_44_1b;
    localparam logic [13:0] SAT_RESET = 14'h28_28;
    // ========================================
    // Arithmetic constants
    localparam int K_FULL = 64;
    localparam int K_MID = 32;
    localparam int OFFS_STATIC = 31;
    localparam int UNITY = 32;
    localparam int MAIN_DELAY = 4;
    localparam int CIP_LATENCY = 2;

    typedef struct packed {
        logic [7:0] y;
        logic [7:0] cr;
        logic [7:0] cb;
    } pix_t;

    typedef struct packed {
        logic [7:0] y;
        logic [7:0] c;
        logic cr_phase;
    } pix422_t;
endpackage : softmix_pkg

// >>> component_softmixer.sv
// Component soft mixer: matrix, picture controls, mixer, 4:2:2 and monitor
// What this block does
// R01 - Accept 8-bit component samples each clock
// R02 - Blank level is a 6-bit unsigned sample
// R03 - RGB to luma and colour difference matrix
// R04 - Bypass matrix for colour difference input
// R05 - Contrast, brightness, saturation and tint controls
// R06 - Host programs level matching picture values
// R07 - Align component with upsampled main video
// R08 - Output is weighted blend over 64
// R09 - Static switch forces factor 0 or 64
// R10 - Static mix factor uses gain and offset
// R11 - Static modes ignore the blank level
// R12 - Dynamic factor follows blank level each pixel
// R13 - Derive non-linear factor from linear one
// R14 - Source mode and clamp select pick operation
// R15 - Non-linear mix needs curve and delay bits
// R16 - Chroma lowpass and 4:2:2 decimation, bypassable
// R17 - Blank-high flag clears on read only when low
// R18 - Blank-level-now bit shows live level
// R19 - Sticky rise and fall flags clear on read
// R20 - Sticky clip flag clears on read
// R21 - Range extend bit widens converter input
// R22 - Non-linear curve monotonic within 0 to 64
// R23 - Reset clears flags, selects main video
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
module component_softmixer
    import softmix_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int BLANK_W = 6
) (
    input wire logic sys_clk, // 20.25 MHz pixel clock
    input wire logic rst_n, // Synchronous reset
    input wire logic clk_en, // Freezes all state when low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire pix_t cip_in, // Component samples, R/G/B or Y/Cr/Cb
    input wire logic [2:0] cip_clip, // Converter clip per channel
    input wire logic [BLANK_W-1:0] blank_level_sample, // Blank level
    input wire pix_t main_in, // Main video, upsampled 4:4:4
    output pix422_t mix_out, // Mixed 4:2:2 stream
    output logic adc_range_extend // Converter range widen
);
    // ========================================
    // Pin synchronisers
    logic [BLANK_W-1:0] fb_s1, fb_s2;
    logic [2:0] clip_s1, clip_s2;
    logic fb_prev;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fb_s1 <= '0;
            fb_s2 <= '0;
            clip_s1 <= '0;
            clip_s2 <= '0;
        end else if (clk_en) begin
            fb_s1 <= blank_level_sample; // R02
            fb_s2 <= fb_s1;
            clip_s1 <= cip_clip;
            clip_s2 <= clip_s1;
        end
    end
    // Blank considered high at upper half of the 6-bit range
    wire fb_high = fb_s2[BLANK_W-1];

    // ========================================
    // Registers
    logic [7:0] mode;
    logic [13:0] mix_reg;
    logic [23:0] pict;
    logic [13:0] sat;
    logic st_high, st_rise, st_fall, st_clip;
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire rd_stat = rd && paddr == REG_STAT;

    function automatic logic mapped(input logic [7:0] a);
        mapped = a == REG_MODE || a == REG_MIX || a == REG_PICT ||
                 a == REG_SAT || a == REG_STAT;
    endfunction : mapped

    assign pready = 1'b1;
    assign pslverr = acc && !mapped(paddr);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode <= MODE_RESET; // R23
            mix_reg <= MIX_RESET;
            pict <= PICT_RESET;
            sat <= SAT_RESET;
        end else if (clk_en && wr) begin
            case (paddr)
                REG_MODE: mode <= pwdata[7:0];
                REG_MIX: mix_reg <= pwdata[13:0];
                REG_PICT: pict <= pwdata[23:0];
                REG_SAT: sat <= pwdata[13:0];
                default: ;
            endcase
        end
    end

    // Set wins over read clear
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_high <= 1'b0; // R23
            st_rise <= 1'b0;
            st_fall <= 1'b0;
            st_clip <= 1'b0;
            fb_prev <= 1'b0;
        end else if (clk_en) begin
            fb_prev <= fb_high;
            if (fb_high) st_high <= 1'b1; // R17
            else if (rd_stat) st_high <= 1'b0; // R17
            if (fb_high && !fb_prev) st_rise <= 1'b1; // R19
            else if (rd_stat) st_rise <= 1'b0; // R19
            if (!fb_high && fb_prev) st_fall <= 1'b1; // R19
            else if (rd_stat) st_fall <= 1'b0; // R19
            if (|clip_s2) st_clip <= 1'b1; // R20
            else if (rd_stat) st_clip <= 1'b0; // R20
        end
    end

    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = '0;
        case (paddr)
            REG_MODE: next_rdata[7:0] = mode;
            REG_MIX: next_rdata[13:0] = mix_reg;
            REG_PICT: next_rdata[23:0] = pict;
            REG_SAT: next_rdata[13:0] = sat;
            REG_STAT: begin
                next_rdata[ST_HIGH_BIT] = st_high;
                next_rdata[ST_NOW_BIT] = fb_high; // R18
                next_rdata[ST_RISE_BIT] = st_rise;
                next_rdata[ST_FALL_BIT] = st_fall;
                next_rdata[ST_CLIP_BIT] = st_clip;
            end
            default: next_rdata = '0;
        endcase
    end
    assign prdata = rd ? next_rdata : '0;

    wire [1:0] src_mode = mode[MODE_SRC_LSB +: 2];
    wire clamp_sel = mode[MODE_CLAMP_BIT];
    wire curve_sel = mode[MODE_CURVE_BIT];
    wire delay_sel = mode[MODE_DELAY_BIT];
    wire yuv_in = mode[MODE_YUV_BIT];
    wire lpf_bypass = mode[MODE_LPFBY_BIT];
    assign adc_range_extend = mode[MODE_XAR_BIT]; // R21
    wire [5:0] mix_gain = mix_reg[MIX_GAIN_LSB +: 6];
    wire [5:0] mix_offset = mix_reg[MIX_OFFS_LSB +: 6];
    wire [5:0] contrast = pict[PICT_CON_LSB +: 6];
    wire signed [7:0] brightness = pict[PICT_BRI_LSB +: 8];
    wire signed [7:0] tint = pict[PICT_TINT_LSB +: 8];
    wire [5:0] sat_cr = sat[SAT_CR_LSB +: 6];
    wire [5:0] sat_cb = sat[SAT_CB_LSB +: 6];

    // ========================================
    // Matrix stage; coefficients scaled by 1024
    function automatic logic [7:0] clip8(input logic signed [19:0] v);
        if (v < 0) clip8 = 8'h00;
        else if (v > 255) clip8 = 8'hff;
        else clip8 = v[7:0];
    endfunction : clip8

    pix_t mtx;
    always_ff @(posedge sys_clk) begin
        logic signed [19:0] r, g, b, yy;
        r = 20'(cip_in.y);
        g = 20'(cip_in.cr);
        b = 20'(cip_in.cb);
        yy = (20'sd306 * r + 20'sd601 * g + 20'sd117 * b) >>> 10; // R03
        if (!rst_n) begin
            mtx <= '0;
        end else if (clk_en) begin
            if (yuv_in) begin
                mtx <= cip_in; // R04
            end else begin
                mtx.y <= clip8(yy); // R01
                // 0.713/0.564 scale keeps differences inside 8 bits
                mtx.cr <= clip8((((r - yy) * 20'sd730) >>> 10) + 20'sd128);
                mtx.cb <= clip8((((b - yy) * 20'sd578) >>> 10) + 20'sd128);
            end
        end
    end

    // ========================================
    // Picture controls; tint as small linear rotation, about 1 deg/step
    pix_t ctl;
    always_ff @(posedge sys_clk) begin
        logic signed [19:0] yv, cr, cb, crs, cbs, t;
        t = 20'(tint);
        if (t > 20) t = 20'sd20;
        if (t < -20) t = -20'sd20;
        cr = 20'(mtx.cr) - 20'sd128;
        cb = 20'(mtx.cb) - 20'sd128;
        yv = ((20'(mtx.y) * 20'(contrast)) >>> 5) + 20'(brightness);
        // Signed gains keep the arithmetic shift right for negative chroma
        crs = (cr * 20'($signed({1'b0, sat_cr}))) >>> 5;
        cbs = (cb * 20'($signed({1'b0, sat_cb}))) >>> 5;
        if (!rst_n) begin
            ctl <= '0;
        end else if (clk_en) begin
            ctl.y <= clip8(yv); // R05
            ctl.cr <= clip8(crs + ((cbs * t) >>> 6) + 20'sd128); // R05
            ctl.cb <= clip8(cbs - ((crs * t) >>> 6) + 20'sd128); // R05
        end
    end

    // ========================================
    // Main video delay to meet the component path
    pix_t main_dly [MAIN_DELAY];
    genvar gi;
    generate
        for (gi = 0; gi < MAIN_DELAY; gi++) begin : g_dly
            pix_t stage_in;
            if (gi == 0) begin : g_head
                assign stage_in = main_in;
            end else begin : g_tail
                assign stage_in = main_dly[gi-1];
            end
            always_ff @(posedge sys_clk) begin
                if (!rst_n) main_dly[gi] <= '0;
                else if (clk_en) main_dly[gi] <= stage_in; // R07
            end
        end
    endgenerate
    // Delay select adds one stage to both main and component paths, lining component up with the factor
    wire pix_t main_al = delay_sel ? main_dly[MAIN_DELAY-1]
                                   : main_dly[MAIN_DELAY-2]; // R07
    pix_t ctl_d;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) ctl_d <= '0;
        else if (clk_en) ctl_d <= ctl;
    end
    wire pix_t cip_al = delay_sel ? ctl_d : ctl;

    // ========================================
    // Mixing factor
    function automatic logic [6:0] sat64(input logic signed [15:0] v);
        if (v < 0) sat64 = 7'd0;
        else if (v > K_FULL) sat64 = 7'(K_FULL);
        else sat64 = v[6:0];
    endfunction : sat64

    // Smoothstep-like curve, monotonic, bounded by 0..64
    function automatic logic [6:0] curve(input logic [6:0] kl);
        logic [15:0] sq;
        sq = 16'(kl) * 16'(kl);
        if (kl < 7'(K_MID)) curve = 7'(sq >> 5);
        else curve = 7'(K_FULL - ((16'(K_FULL - kl) ** 2) >> 5));
    endfunction : curve

    logic [6:0] linear_mix_coeff, k_nl, k;
    always_ff @(posedge sys_clk) begin
        logic signed [15:0] lin;
        lin = 16'($signed({1'b0, mix_gain})) *
              (16'(fb_s2) - 16'(mix_offset)) + 16'sd32; // R12
        if (!rst_n) begin
            linear_mix_coeff <= 7'(K_FULL);
            k_nl <= 7'(K_FULL);
        end else if (clk_en) begin
            linear_mix_coeff <= sat64(lin); // R12
            k_nl <= curve(sat64(lin)); // R13 R22
        end
    end

    always_comb begin
        logic signed [15:0] st;
        st = 16'($signed({1'b0, mix_gain})) *
             (16'(OFFS_STATIC) - 16'(mix_offset)) + 16'(K_MID); // R10
        case (src_mode)
            SRC_MAIN: k = 7'(K_FULL); // R09 R14
            SRC_MIX: begin
                if (clamp_sel) k = sat64(st); // R10 R11
                else if (curve_sel && delay_sel) k = k_nl; // R15
                else k = linear_mix_coeff; // R14
            end
            default: k = 7'd0; // R09 R14
        endcase
    end

    // ========================================
    // Blend
    function automatic logic [7:0] blend(input logic [7:0] m,
                                         input logic [7:0] c,
                                         input logic [6:0] kk);
        logic [15:0] s;
        s = 16'(m) * 16'(kk) + 16'(c) * 16'(7'(K_FULL) - kk) + 16'd32;
        blend = s[13:6];
    endfunction : blend

    pix_t mixd;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mixd <= '0;
        end else if (clk_en) begin
            mixd.y <= blend(main_al.y, cip_al.y, k); // R08
            mixd.cr <= blend(main_al.cr, cip_al.cr, k); // R08
            mixd.cb <= blend(main_al.cb, cip_al.cb, k); // R08
        end
    end

    // ========================================
    // Chroma [1 2 1]/4 lowpass, then alternate Cb/Cr for 4:2:2
    logic [7:0] cr1, cr2, cb1, cb2;
    logic phase;
    always_ff @(posedge sys_clk) begin
        logic [9:0] fcr, fcb;
        fcr = 10'(cr2) + 10'(mixd.cr) + {1'b0, cr1, 1'b0} + 10'd2;
        fcb = 10'(cb2) + 10'(mixd.cb) + {1'b0, cb1, 1'b0} + 10'd2;
        if (!rst_n) begin
            cr1 <= '0;
            cr2 <= '0;
            cb1 <= '0;
            cb2 <= '0;
            phase <= 1'b0;
            mix_out <= '0;
        end else if (clk_en) begin
            cr1 <= mixd.cr;
            cr2 <= cr1;
            cb1 <= mixd.cb;
            cb2 <= cb1;
            phase <= !phase; // R16
            mix_out.y <= mixd.y;
            mix_out.cr_phase <= phase;
            if (lpf_bypass)
                mix_out.c <= phase ? mixd.cr : mixd.cb; // R16
            else
                mix_out.c <= phase ? fcr[9:2] : fcb[9:2]; // R16
        end
    end
endmodule : component_softmixer

// >>> component_softmixer_monitor.sv
// Port checker for the component soft mixer
`timescale 1ns/1ps
module component_softmixer_monitor
    import softmix_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int BLANK_W = 6
) (
    input wire logic sys_clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic clk_en, // Run
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [7:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire pix_t cip_in, // Component
    input wire logic [2:0] cip_clip, // Clip
    input wire logic [BLANK_W-1:0] blank_level_sample, // Blank
    input wire pix_t main_in, // Main
    input wire pix422_t mix_out, // Output
    input wire logic adc_range_extend // Range
);
    // ========================================
    // Shadow state
    logic acc;
    logic stat_rd;
    logic blank_q;
    logic [2:0] clip_q;
    pix_t main_q;
    logic [7:0] mode;
    logic [3:0] blank_age;
    logic [3:0] clip_age;
    logic [3:0] quiet;
    assign acc = psel && penable && clk_en;
    assign stat_rd = acc && !pwrite && paddr == REG_STAT;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode <= MODE_RESET;
        end else if (acc && pwrite && paddr == REG_MODE) begin
            mode <= pwdata[7:0];
        end
    end
    // Ages saturate, so long quiet spells stay valid
    always_ff @(posedge sys_clk) begin
        blank_q <= blank_level_sample[BLANK_W-1];
        clip_q <= cip_clip;
        main_q <= main_in;
        if (!rst_n || blank_q != blank_level_sample[BLANK_W-1]) begin
            blank_age <= 4'h0;
        end else begin
            blank_age <= blank_age + {3'h0, blank_age != 4'hf};
        end
        if (!rst_n || clip_q != cip_clip) begin
            clip_age <= 4'h0;
        end else begin
            clip_age <= clip_age + {3'h0, clip_age != 4'hf};
        end
        if (!rst_n || main_q != main_in || (acc && pwrite)) begin
            quiet <= 4'h0;
        end else begin
            quiet <= quiet + {3'h0, quiet != 4'hf};
        end
    end
    // ========================================
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_rst_out;
        $rose(rst_n) |-> mix_out == '0;
    endproperty
    a_rst_out: assert property (p_rst_out)
        else $error("output not cleared by reset");
    property p_rst_xar;
        $rose(rst_n) |-> !adc_range_extend;
    endproperty
    a_rst_xar: assert property (p_rst_xar)
        else $error("range extend set after reset");
    property p_err;
        acc && paddr > REG_STAT |-> pslverr && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err)
        else $error("unmapped access not refused");
    property p_xar;
        acc && pwrite && paddr == REG_MODE
            |=> adc_range_extend == $past(pwdata[MODE_XAR_BIT]);
    endproperty
    a_xar: assert property (p_xar)
        else $error("range extend does not follow mode write");
    property p_now;
        stat_rd && blank_age > 4'h5
            |-> prdata[ST_NOW_BIT] == blank_level_sample[BLANK_W-1];
    endproperty
    a_now: assert property (p_now)
        else $error("live blank bit wrong");
    property p_high;
        stat_rd && blank_age > 4'h5 && blank_level_sample[BLANK_W-1]
            |-> prdata[ST_HIGH_BIT];
    endproperty
    a_high: assert property (p_high)
        else $error("blank high flag missing");
    property p_clr;
        stat_rd && blank_age > 4'h5 ##3 stat_rd && blank_age > 4'h8
            |-> !prdata[ST_RISE_BIT] && !prdata[ST_FALL_BIT]
            && prdata[ST_HIGH_BIT] == blank_level_sample[BLANK_W-1];
    endproperty
    a_clr: assert property (p_clr)
        else $error("blank flags not cleared by read");
    property p_clip;
        stat_rd && clip_age > 4'h5 && cip_clip != 3'h0
            |-> prdata[ST_CLIP_BIT];
    endproperty
    a_clip: assert property (p_clip)
        else $error("clip flag missing");
    property p_main;
        quiet > 4'h9 && mode[1:0] == SRC_MAIN |-> mix_out.y == main_in.y;
    endproperty
    a_main: assert property (p_main)
        else $error("forced main output wrong");
endmodule : component_softmixer_monitor

bind component_softmixer component_softmixer_monitor #(
    .DATA_W(DATA_W), .BLANK_W(BLANK_W)) u_mon (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cip_in(cip_in), .cip_clip(cip_clip),
    .blank_level_sample(blank_level_sample), .main_in(main_in),
    .mix_out(mix_out), .adc_range_extend(adc_range_extend));

// >>> component_source_model.sv
// Component source seen through its sampling converters
`timescale 1ns/1ps
module component_source_model
    import softmix_pkg::*;
(
    input wire logic sys_clk, // Converter clock
    input wire pix_t level, // Analogue level per channel
    input wire logic [5:0] blank, // Fast blank level
    output pix_t cip_in, // Sampled channels
    output logic [2:0] cip_clip, // Converter clip flags
    output logic [5:0] blank_level_sample // Sampled blank level
);
    // Full-scale code stands for an overdriven input
    always_ff @(posedge sys_clk) begin
        cip_in <= level;
        blank_level_sample <= blank;
        cip_clip <= {level.y == 8'hff, level.cr == 8'hff,
                     level.cb == 8'hff};
    end
endmodule : component_source_model

// >>> test_component_softmixer.sv
// Self-checking bench for the component soft mixer
`timescale 1ns/1ps
module test_component_softmixer import softmix_pkg::*;;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic adc_range_extend;
    pix_t level = '{8'h64, 8'h80, 8'h80};
    pix_t main_in = '{8'hc8, 8'h3c, 8'h5a};
    pix_t cip_in;
    logic [2:0] cip_clip;
    logic [5:0] blank = 6'h00;
    logic [5:0] blank_level_sample;
    pix422_t mix_out;
    int bad_count = 0;
    int comparisons = 0;
    logic [31:0] q;
    logic e;
    always #12.5 sys_clk = ~sys_clk;
    component_source_model src (.sys_clk(sys_clk), .level(level),
        .blank(blank), .cip_in(cip_in), .cip_clip(cip_clip),
        .blank_level_sample(blank_level_sample));
    component_softmixer dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cip_in(cip_in), .cip_clip(cip_clip),
        .blank_level_sample(blank_level_sample), .main_in(main_in),
        .mix_out(mix_out), .adc_range_extend(adc_range_extend));
    // ========================================
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge sys_clk);
        end
        if (n == 16) bad_count++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, q, exp);
    endtask : rd_chk
    task automatic settle();
        repeat (12) @(posedge sys_clk);
    endtask : settle
    task automatic mix_chk(input string what, input logic [7:0] exp);
        settle();
        check(what, {24'h0, mix_out.y}, {24'h0, exp});
    endtask : mix_chk
    // ========================================
    // Scenarios
    task automatic t_reset();
        rd_chk("mode", REG_MODE, {24'h0, MODE_RESET});
        rd_chk("mix", REG_MIX, 32'h0);
        rd_chk("pict", REG_PICT, {8'h0, PICT_RESET});
        rd_chk("sat", REG_SAT, {18'h0, SAT_RESET});
        rd_chk("stat", REG_STAT, 32'h0);
        rd_chk("hole", 8'h14, 32'h0);
        check("hole err", {31'h0, e}, 32'h1);
        check("xar", {31'h0, adc_range_extend}, 32'h0);
        mix_chk("reset main", 8'hc8);
    endtask : t_reset
    task automatic t_switch();
        apb(1'b1, REG_PICT, 32'h0000_441b);
        apb(1'b1, REG_SAT, 32'h0000_2828);
        apb(1'b1, REG_MODE, 32'h22);
        mix_chk("level match", 8'h98);
        apb(1'b1, REG_PICT, 32'h0000_0020);
        apb(1'b1, REG_SAT, 32'h0000_2020);
        blank <= 6'h3f;
        apb(1'b1, REG_MODE, 32'h23);
        mix_chk("sw main", 8'hc8);
        apb(1'b1, REG_MODE, 32'h20);
        mix_chk("sw cip 00", 8'h64);
        apb(1'b1, REG_MODE, 32'h22);
        blank <= 6'h00;
        mix_chk("sw cip 10", 8'h64);
        apb(1'b1, REG_MODE, 32'h02);
        mix_chk("matrix", 8'h77);
    endtask : t_switch
    task automatic t_static();
        logic [13:0] mx [4] = '{14'h1f01, 14'h003f, 14'h3f3f, 14'h1e02};
        logic [7:0] ex [4] = '{8'h96, 8'hc8, 8'h64, 8'h99};
        apb(1'b1, REG_MODE, 32'h25);
        for (int i = 0; i < 4; i++) begin
            blank <= i[0] ? 6'h3f : 6'h00;
            apb(1'b1, REG_MIX, {18'h0, mx[i]});
            mix_chk("static", ex[i]);
        end
    endtask : t_static
    task automatic t_dynamic();
        logic [13:0] mx [4] = '{14'h1401, 14'h1401, 14'h1402, 14'h3002};
        logic [5:0] bl [4] = '{6'h28, 6'h00, 6'h3f, 6'h00};
        logic [7:0] ex [4] = '{8'hb5, 8'h77, 8'hc8, 8'h64};
        apb(1'b1, REG_MODE, 32'h21);
        for (int i = 0; i < 4; i++) begin
            blank <= bl[i];
            apb(1'b1, REG_MIX, {18'h0, mx[i]});
            mix_chk("dynamic", ex[i]);
        end
        apb(1'b1, REG_MODE, 32'h39);
        for (int i = 2; i < 4; i++) begin
            blank <= bl[i];
            apb(1'b1, REG_MIX, {18'h0, mx[i]});
            mix_chk("curve", ex[i]);
        end
    endtask : t_dynamic
    task automatic t_chroma();
        logic p;
        for (int b = 0; b < 2; b++) begin
            apb(1'b1, REG_MODE, {25'h0, b[0], 6'h23});
            settle();
            p = mix_out.cr_phase;
            check("chroma", {24'h0, mix_out.c}, p ? 32'h3c : 32'h5a);
            @(posedge sys_clk);
            check("phase", {31'h0, mix_out.cr_phase}, {31'h0, ~p});
            check("chroma", {24'h0, mix_out.c}, p ? 32'h5a : 32'h3c);
            clk_en <= 1'b0;
            repeat (2) @(posedge sys_clk);
            check("frozen", {31'h0, mix_out.cr_phase}, {31'h0, p});
            clk_en <= 1'b1;
        end
    endtask : t_chroma
    task automatic t_flags();
        settle();
        apb(1'b0, REG_STAT, 32'h0);
        blank <= 6'h20;
        settle();
        rd_chk("hi", REG_STAT, 32'h7);
        rd_chk("hi again", REG_STAT, 32'h3);
        blank <= 6'h1f;
        settle();
        rd_chk("lo", REG_STAT, 32'h9);
        rd_chk("lo again", REG_STAT, 32'h0);
        level <= '{8'hff, 8'h80, 8'h80};
        settle();
        rd_chk("clip", REG_STAT, 32'h10);
        level <= '{8'h64, 8'h80, 8'h80};
        settle();
        rd_chk("clip held", REG_STAT, 32'h10);
        rd_chk("clip clear", REG_STAT, 32'h0);
    endtask : t_flags
    task automatic t_xar();
        apb(1'b1, REG_MODE, 32'h83);
        check("xar on", {31'h0, adc_range_extend}, 32'h1);
        rd_chk("mode back", REG_MODE, 32'h83);
        apb(1'b1, REG_MODE, 32'h03);
        check("xar off", {31'h0, adc_range_extend}, 32'h0);
    endtask : t_xar
    // ========================================
    // Run control
    task automatic wrap_up();
        $display("bad_count %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_switch();
        t_static();
        t_dynamic();
        t_chroma();
        t_flags();
        t_xar();
        wrap_up();
    end
    // Whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        wrap_up();
    end
endmodule : test_component_softmixer
